// ### lanes_pkg.sv
// constants, state encoding and command decode for the bus lane block
// assumes a 64-bit multiplexed bus clocked by the bus feedback clock
package lanes_pkg;

  localparam int AD_W     = 64;
  localparam int HALF_W   = 32;
  localparam int CBE_W    = 8;
  localparam int CMD_W    = 4;
  localparam int HALVES   = 2;
  localparam int WR_BIT   = 0;

  localparam logic [63:0] AD_PARK_VAL  = 64'h0000_0000_0000_0000;
  localparam logic [7:0]  CBE_PARK_VAL = 8'hFF;
  localparam logic [3:0]  CBE_HI_ADDR  = 4'hF;
  localparam logic [1:0]  OE_BOTH      = 2'h3;
  localparam logic [1:0]  OE_NONE      = 2'h0;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_ADDR = 2'h1,
    ST_DATA = 2'h3,
    ST_TURN = 2'h2
  } lane_state_type;

  // write commands carry a one in bit zero of the encoding
  function automatic logic cmd_is_write(input logic [3:0] cmd);
    return cmd[WR_BIT];
  endfunction

endpackage

// ### sync2.sv
// two flip-flop synchroniser for levels
// assumes d_in is stable for several destination clocks
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_type;

  sync_type s_r;
  sync_type s_nxt;

  always_comb
  begin
    s_nxt.meta = d_in;
    s_nxt.q    = s_r.meta;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign q_out = s_r.q;

endmodule

// ### word_cross.sv
// toggle handshake carrying one word between two clock domains
// assumes the destination side takes each word with dst_ready_in
`timescale 1ns/100ps
module word_cross #(
  parameter int W = 8
) (
  input  wire logic         src_clk_in,
  input  wire logic         src_rst_in,
  input  wire logic         src_valid_in,
  input  wire logic [W-1:0] src_data_in,
  output logic              src_ready_out,
  input  wire logic         dst_clk_in,
  input  wire logic         dst_rst_in,
  input  wire logic         dst_ready_in,
  output logic              dst_valid_out,
  output logic      [W-1:0] dst_data_out
);

  typedef struct packed {
    logic         busy;
    logic         req;
    logic [W-1:0] data;
  } src_type;

  typedef struct packed {
    logic         seen;
    logic         ack;
    logic         valid;
    logic [W-1:0] data;
  } dst_type;

  src_type s_r;
  src_type s_nxt;
  dst_type d_r;
  dst_type d_nxt;
  logic    ack_sync;
  logic    req_sync;

  sync2 #(.W(1)) u_ack_sync (
    .clk_in (src_clk_in),
    .rst_in (src_rst_in),
    .d_in   (d_r.ack),
    .q_out  (ack_sync)
  );

  sync2 #(.W(1)) u_req_sync (
    .clk_in (dst_clk_in),
    .rst_in (dst_rst_in),
    .d_in   (s_r.req),
    .q_out  (req_sync)
  );

  always_comb
  begin
    s_nxt = s_r;
    if (s_r.busy && ack_sync == s_r.req)
    begin
      s_nxt.busy = 1'b0;
    end
    else if (!s_r.busy && src_valid_in)
    begin
      s_nxt.busy = 1'b1;
      s_nxt.req  = ~s_r.req;
      s_nxt.data = src_data_in;
    end
  end

  // source word is held while busy, so the wide read here is safe
  always_comb
  begin
    d_nxt = d_r;
    if (d_r.valid && dst_ready_in)
    begin
      d_nxt.valid = 1'b0;
      d_nxt.ack   = d_r.seen;
    end
    else if (!d_r.valid && req_sync != d_r.seen)
    begin
      d_nxt.valid = 1'b1;
      d_nxt.seen  = req_sync;
      d_nxt.data  = s_r.data;
    end
  end

  always_ff @(posedge src_clk_in)
  begin
    if (src_rst_in)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge dst_clk_in)
  begin
    if (dst_rst_in)
    begin
      d_r <= '0;
    end
    else
    begin
      d_r <= d_nxt;
    end
  end

  assign src_ready_out = !s_r.busy;
  assign dst_valid_out = d_r.valid;
  assign dst_data_out  = d_r.data;

endmodule

// ### pcix_lanes.sv
// address/data and command/byte-enable lanes of the parallel bus side
// assumes bus pins and target-side inputs are synchronous to the bus clock
`timescale 1ns/100ps
module pcix_lanes (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic [63:0] req_addr_in,
  input  wire logic [3:0]  req_cmd_in,
  input  wire logic [7:0]  req_be_n_in,
  input  wire logic [63:0] req_wdata_in,
  input  wire logic        bus_feedback_clock_in,
  input  wire logic        frame_n_in,
  output logic             frame_n_out,
  output logic             frame_oe_out,
  input  wire logic        irdy_n_in,
  output logic             irdy_n_out,
  output logic             irdy_oe_out,
  input  wire logic        trdy_n_in,
  input  wire logic        park_n_in,
  input  wire logic        tgt_sel_in,
  input  wire logic [63:0] tgt_rdata_in,
  input  wire logic [7:0]  tgt_be_n_in,
  input  wire logic [63:0] ad_in,
  output logic      [63:0] ad_out,
  output logic      [1:0]  ad_oe_out,
  input  wire logic [7:0]  cbe_n_in,
  output logic      [7:0]  cbe_n_out,
  output logic      [1:0]  cbe_oe_out,
  output logic             rx_valid_out,
  output logic      [63:0] rx_data_out,
  output logic      [7:0]  rx_be_n_out
);

  localparam int REQ_W = 2 * lanes_pkg::AD_W + lanes_pkg::CMD_W
                         + lanes_pkg::CBE_W;

  typedef struct packed {
    lanes_pkg::lane_state_type st;
    logic        frame_q;
    logic        tgt_wr;
    logic [63:0] ad;
    logic [1:0]  ad_oe;
    logic [7:0]  cbe;
    logic [1:0]  cbe_oe;
    logic        frame_n;
    logic        frame_oe;
    logic        irdy_n;
    logic        irdy_oe;
    logic        rx_go;
    logic [63:0] rx_data;
    logic [7:0]  rx_be;
  } bus_type;

  bus_type s_r;
  bus_type s_nxt;

  logic             bus_rst;
  logic             q_valid;
  logic [REQ_W-1:0] q_data;
  logic [63:0]      q_addr;
  logic [3:0]       q_cmd;
  logic [7:0]       q_be;
  logic [63:0]      q_wdata;
  logic             q_wr;
  logic             idle_now;
  logic             xfer;
  logic             addr_seen;
  logic             in_txn;
  logic             tgt_drv;

  // reset is carried into the bus clock as a plain level
  sync2 #(.W(1)) u_rst_sync (
    .clk_in (bus_feedback_clock_in),
    .rst_in (1'b0),
    .d_in   (sys_rst_in),
    .q_out  (bus_rst)
  );

  // one request in flight; the core sees ready again after turnaround
  word_cross #(.W(REQ_W)) u_req_cross (
    .src_clk_in    (clk_in),
    .src_rst_in    (sys_rst_in),
    .src_valid_in  (req_valid_in),
    .src_data_in   ({req_addr_in, req_cmd_in, req_be_n_in, req_wdata_in}),
    .src_ready_out (req_ready_out),
    .dst_clk_in    (bus_feedback_clock_in),
    .dst_rst_in    (bus_rst),
    .dst_ready_in  (s_r.st == lanes_pkg::ST_TURN),
    .dst_valid_out (q_valid),
    .dst_data_out  (q_data)
  );

  assign {q_addr, q_cmd, q_be, q_wdata} = q_data;
  assign q_wr      = lanes_pkg::cmd_is_write(q_cmd);
  assign idle_now  = frame_n_in && irdy_n_in;
  assign xfer      = !irdy_n_in && !trdy_n_in;
  assign addr_seen = !frame_n_in && s_r.frame_q;
  assign in_txn    = !idle_now && !addr_seen;
  assign tgt_drv   = tgt_sel_in && in_txn && !s_r.tgt_wr;

  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.frame_q = frame_n_in;
    s_nxt.rx_go   = 1'b0;
    if (addr_seen && s_r.st == lanes_pkg::ST_IDLE)
    begin
      s_nxt.tgt_wr = lanes_pkg::cmd_is_write(cbe_n_in[3:0]);
    end
    case (s_r.st)
      lanes_pkg::ST_IDLE:
      begin
        if (q_valid && !park_n_in && idle_now)
        begin
          s_nxt.st = lanes_pkg::ST_ADDR;
        end
        else if (tgt_sel_in && in_txn && s_r.tgt_wr && xfer)
        begin
          s_nxt.rx_go   = 1'b1;
          s_nxt.rx_data = ad_in;
          s_nxt.rx_be   = cbe_n_in;
        end
      end
      lanes_pkg::ST_ADDR:
      begin
        s_nxt.st = lanes_pkg::ST_DATA;
      end
      lanes_pkg::ST_DATA:
      begin
        if (xfer)
        begin
          s_nxt.st = lanes_pkg::ST_TURN;
          if (!q_wr)
          begin
            s_nxt.rx_go   = 1'b1;
            s_nxt.rx_data = ad_in;
            s_nxt.rx_be   = cbe_n_in;
          end
        end
      end
      lanes_pkg::ST_TURN:
      begin
        s_nxt.st = lanes_pkg::ST_IDLE;
      end
      default:
      begin
        s_nxt.st = lanes_pkg::ST_IDLE;
      end
    endcase

    // pin drive follows the next state so it lines up with the phase
    s_nxt.ad       = lanes_pkg::AD_PARK_VAL;
    s_nxt.ad_oe    = lanes_pkg::OE_NONE;
    s_nxt.cbe      = lanes_pkg::CBE_PARK_VAL;
    s_nxt.cbe_oe   = lanes_pkg::OE_NONE;
    s_nxt.frame_n  = 1'b1;
    s_nxt.frame_oe = 1'b0;
    s_nxt.irdy_n   = 1'b1;
    s_nxt.irdy_oe  = 1'b0;
    case (s_nxt.st)
      lanes_pkg::ST_ADDR:
      begin
        s_nxt.frame_n  = 1'b0;
        s_nxt.frame_oe = 1'b1;
        s_nxt.irdy_oe  = 1'b1;
        s_nxt.ad       = q_addr;
        s_nxt.ad_oe    = lanes_pkg::OE_BOTH;
        s_nxt.cbe      = {lanes_pkg::CBE_HI_ADDR, q_cmd};
        s_nxt.cbe_oe   = lanes_pkg::OE_BOTH;
      end
      lanes_pkg::ST_DATA:
      begin
        // single data phase, so FRAME# rises together with IRDY# falling
        s_nxt.frame_oe = 1'b1;
        s_nxt.irdy_n   = 1'b0;
        s_nxt.irdy_oe  = 1'b1;
        if (q_wr)
        begin
          s_nxt.ad     = q_wdata;
          s_nxt.ad_oe  = lanes_pkg::OE_BOTH;
          s_nxt.cbe    = q_be;
          s_nxt.cbe_oe = lanes_pkg::OE_BOTH;
        end
      end
      lanes_pkg::ST_TURN:
      begin
        s_nxt.frame_oe = 1'b1;
        s_nxt.irdy_oe  = 1'b1;
      end
      default:
      begin
        if (tgt_drv)
        begin
          s_nxt.ad     = tgt_rdata_in;
          s_nxt.ad_oe  = lanes_pkg::OE_BOTH;
          s_nxt.cbe    = tgt_be_n_in;
          s_nxt.cbe_oe = lanes_pkg::OE_BOTH;
        end
        else if (idle_now && !park_n_in)
        begin
          s_nxt.ad_oe  = lanes_pkg::OE_BOTH;
          s_nxt.cbe_oe = lanes_pkg::OE_BOTH;
        end
      end
    endcase
  end

  always_ff @(posedge bus_feedback_clock_in)
  begin
    if (bus_rst)
    begin
      s_r         <= '0;
      s_r.frame_q <= 1'b1;
      s_r.frame_n <= 1'b1;
      s_r.irdy_n  <= 1'b1;
      s_r.cbe     <= lanes_pkg::CBE_PARK_VAL;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign ad_out       = s_r.ad;
  assign ad_oe_out    = s_r.ad_oe;
  assign cbe_n_out    = s_r.cbe;
  assign cbe_oe_out   = s_r.cbe_oe;
  assign frame_n_out  = s_r.frame_n;
  assign frame_oe_out = s_r.frame_oe;
  assign irdy_n_out   = s_r.irdy_n;
  assign irdy_oe_out  = s_r.irdy_oe;
  assign rx_valid_out = s_r.rx_go;
  assign rx_data_out  = s_r.rx_data;
  assign rx_be_n_out  = s_r.rx_be;

  property p_addr_phase;
    @(posedge bus_feedback_clock_in) disable iff (bus_rst)
    s_r.st == lanes_pkg::ST_ADDR |-> !frame_n_out && frame_oe_out
      && ad_oe_out == lanes_pkg::OE_BOTH && ad_out == q_addr
      && $past(frame_n_out);
  endproperty
  a_addr_phase: assert property (p_addr_phase)
    else $error("address phase not driven on first frame clock");

  property p_data_after_addr;
    @(posedge bus_feedback_clock_in) disable iff (bus_rst)
    s_r.st == lanes_pkg::ST_ADDR |=> s_r.st == lanes_pkg::ST_DATA
      && !irdy_n_out && irdy_oe_out;
  endproperty
  a_data_after_addr: assert property (p_data_after_addr)
    else $error("data phase does not follow address phase");

  property p_xfer_only;
    @(posedge bus_feedback_clock_in) disable iff (bus_rst)
    rx_valid_out |-> $past(!irdy_n_in && !trdy_n_in);
  endproperty
  a_xfer_only: assert property (p_xfer_only)
    else $error("word taken without both ready strobes");

  property p_park_idle;
    @(posedge bus_feedback_clock_in) disable iff (bus_rst)
    (s_r.st == lanes_pkg::ST_IDLE && ad_oe_out != lanes_pkg::OE_NONE
      && !$past(tgt_drv)) |-> $past(frame_n_in && irdy_n_in && !park_n_in);
  endproperty
  a_park_idle: assert property (p_park_idle)
    else $error("park drive outside an idle parked bus");

  property p_park_drive;
    @(posedge bus_feedback_clock_in) disable iff (bus_rst)
    (s_r.st == lanes_pkg::ST_IDLE && frame_n_in && irdy_n_in && !park_n_in
      && !q_valid) |=> ad_oe_out == lanes_pkg::OE_BOTH
      && cbe_oe_out == lanes_pkg::OE_BOTH;
  endproperty
  a_park_drive: assert property (p_park_drive)
    else $error("parked idle bus left floating");

  property p_cmd_lanes;
    @(posedge bus_feedback_clock_in) disable iff (bus_rst)
    $rose(frame_oe_out) |-> cbe_n_out[3:0] == q_cmd
      && cbe_oe_out == lanes_pkg::OE_BOTH;
  endproperty
  a_cmd_lanes: assert property (p_cmd_lanes)
    else $error("command missing in address phase");

  property p_write_be;
    @(posedge bus_feedback_clock_in) disable iff (bus_rst)
    (s_r.st == lanes_pkg::ST_DATA && q_wr) |-> cbe_n_out == q_be
      && cbe_oe_out == lanes_pkg::OE_BOTH && ad_out == q_wdata;
  endproperty
  a_write_be: assert property (p_write_be)
    else $error("write byte enables not driven by initiator");

  property p_read_be;
    @(posedge bus_feedback_clock_in) disable iff (bus_rst)
    (s_r.st == lanes_pkg::ST_DATA && !q_wr) |-> cbe_oe_out == lanes_pkg::OE_NONE
      && ad_oe_out == lanes_pkg::OE_NONE;
  endproperty
  a_read_be: assert property (p_read_be)
    else $error("initiator drives byte enables on a read");

  property p_release;
    @(posedge bus_feedback_clock_in) disable iff (bus_rst)
    (s_nxt.st == lanes_pkg::ST_IDLE && !tgt_drv
      && !(idle_now && !park_n_in)) |=> ad_oe_out == lanes_pkg::OE_NONE
      && cbe_oe_out == lanes_pkg::OE_NONE;
  endproperty
  a_release: assert property (p_release)
    else $error("lanes driven while not owner");

endmodule

// ### bus_agent.sv
// far-side agents of the parallel bus: arbiter grant, target, initiator
// assumes the bench resolves each shared line from every party's enable
`timescale 1ns/100ps
module bus_agent (
  input  wire logic        bclk_in,
  input  wire logic        frame_n_in,
  input  wire logic        irdy_n_in,
  input  wire logic [63:0] ad_in,
  input  wire logic [7:0]  cbe_n_in,
  output logic             park_n_out,
  output logic             trdy_n_out,
  output logic             frame_n_out,
  output logic             irdy_n_out,
  output logic             strobe_oe_out,
  output logic      [63:0] ad_out,
  output logic             ad_oe_out,
  output logic      [7:0]  cbe_n_out,
  output logic             cbe_oe_out
);
  logic        frame_d_r = 1'b1;
  logic [63:0] addr_r;
  logic [3:0]  cmd_r;
  logic [63:0] data_r;
  logic [7:0]  be_n_r;
  int          xfer_r = 0;

  initial
  begin
    park_n_out = 1'b1;
    trdy_n_out = 1'b1;
    frame_n_out = 1'b1;
    irdy_n_out = 1'b1;
    strobe_oe_out = 1'b0;
    ad_out = 64'h0;
    ad_oe_out = 1'b0;
    cbe_n_out = 8'hFF;
    cbe_oe_out = 1'b0;
  end

  // what every agent on the bus sees at each edge
  always @(posedge bclk_in)
  begin
    frame_d_r <= frame_n_in;
    if (frame_d_r === 1'b1 && frame_n_in === 1'b0)
    begin
      addr_r <= ad_in;
      cmd_r  <= cbe_n_in[3:0];
    end
    if (irdy_n_in === 1'b0 && trdy_n_out === 1'b0)
    begin
      data_r <= ad_in;
      be_n_r <= cbe_n_in;
      xfer_r <= xfer_r + 1;
    end
  end

  task automatic grant(input logic v);
    @(negedge bclk_in);
    park_n_out = v;
  endtask

  // irdy alone keeps the bus busy without a transaction
  task automatic stall(input logic v);
    @(negedge bclk_in);
    irdy_n_out = v;
    strobe_oe_out = !v;
  endtask

  // target answer to the device as initiator, after some wait states
  task automatic respond(input int waits, input logic rd,
                         input logic [63:0] rdata, input logic [7:0] rbe);
    int n;
    n = 0;
    do
    begin
      @(negedge bclk_in);
      n++;
    end
    while (irdy_n_in !== 1'b0 && n < 300);
    repeat (waits) @(negedge bclk_in);
    trdy_n_out = 1'b0;
    ad_out = rdata;
    ad_oe_out = rd;
    cbe_n_out = rbe;
    cbe_oe_out = rd;
    @(negedge bclk_in);
    trdy_n_out = 1'b1;
    ad_oe_out = 1'b0;
    cbe_oe_out = 1'b0;
  endtask

  // one-phase transaction to the device; one irdy-only wait state
  task automatic initiate(input logic [63:0] addr, input logic [3:0] cmd,
                          input logic [63:0] data, input logic [7:0] be);
    @(negedge bclk_in);
    frame_n_out = 1'b0;
    strobe_oe_out = 1'b1;
    ad_out = addr;
    ad_oe_out = 1'b1;
    cbe_n_out = {4'hF, cmd};
    cbe_oe_out = 1'b1;
    @(negedge bclk_in);
    frame_n_out = 1'b1;
    irdy_n_out = 1'b0;
    ad_out = data;
    ad_oe_out = cmd[lanes_pkg::WR_BIT];
    cbe_n_out = be;
    cbe_oe_out = cmd[lanes_pkg::WR_BIT];
    @(negedge bclk_in);
    trdy_n_out = 1'b0;
    @(negedge bclk_in);
    irdy_n_out = 1'b1;
    trdy_n_out = 1'b1;
    ad_oe_out = 1'b0;
    cbe_oe_out = 1'b0;
    @(negedge bclk_in);
    strobe_oe_out = 1'b0;
  endtask
endmodule

// ### test_pcix_lanes.sv
// bench for the bus lanes: core requests, far-side agents, target traffic
// assumes bus_agent plays every outside party; contention shows as unknown
`timescale 1ns/100ps
module test_pcix_lanes;
  logic        clk = 1'b0;
  logic        bclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_ready;
  logic [63:0] req_addr = 64'h0;
  logic [3:0]  req_cmd = 4'h0;
  logic [7:0]  req_be_n = 8'hFF;
  logic [63:0] req_wdata = 64'h0;
  logic        tgt_sel = 1'b0;
  logic [63:0] tgt_rdata = 64'h0123_4567_89AB_CDEF;
  logic [7:0]  tgt_be_n = 8'hC3;
  logic        d_frame_n, d_frame_oe, d_irdy_n, d_irdy_oe;
  logic        park_n, trdy_n, a_frame_n, a_irdy_n, a_soe, a_ad_oe, a_cbe_oe;
  logic [63:0] ad_out, a_ad, ad_bus, rx_data, rx_d;
  logic [7:0]  cbe_out, a_cbe, cbe_bus, rx_be, rx_b;
  logic [1:0]  ad_oe, cbe_oe;
  logic        rx_valid, frame_bus, irdy_bus;
  logic [63:0] flt = 64'hA5A5_5A5A_A5A5_5A5A;
  int          rx_cnt = 0;
  int          bad_count = 0;
  int          cmp_count = 0;

  initial forever #2 clk = ~clk;
  initial
  begin
    #3.1;
    forever #6 bclk = ~bclk;
  end

  // released lines without a pull-up wander every cycle
  always @(posedge bclk) flt <= ~flt;
  always @(posedge bclk)
    if (rx_valid === 1'b1)
    begin
      rx_cnt <= rx_cnt + 1;
      rx_d   <= rx_data;
      rx_b   <= rx_be;
    end

  assign frame_bus = (d_frame_oe && a_soe) ? 1'bx : d_frame_oe ? d_frame_n
                     : a_soe ? a_frame_n : 1'b1;
  assign irdy_bus = (d_irdy_oe && a_soe) ? 1'bx : d_irdy_oe ? d_irdy_n
                    : a_soe ? a_irdy_n : 1'b1;
  for (genvar h = 0; h < 2; h++)
  begin : g_half
    assign ad_bus[h*32+:32] = (ad_oe[h] && a_ad_oe) ? 32'hx
      : ad_oe[h] ? ad_out[h*32+:32] : a_ad_oe ? a_ad[h*32+:32] : flt[h*32+:32];
    assign cbe_bus[h*4+:4] = (cbe_oe[h] && a_cbe_oe) ? 4'hx
      : cbe_oe[h] ? cbe_out[h*4+:4] : a_cbe_oe ? a_cbe[h*4+:4] : flt[h*4+:4];
  end

  pcix_lanes u_dut (
    .clk_in(clk), .sys_rst_in(sys_rst), .req_valid_in(req_valid),
    .req_ready_out(req_ready), .req_addr_in(req_addr), .req_cmd_in(req_cmd),
    .req_be_n_in(req_be_n), .req_wdata_in(req_wdata),
    .bus_feedback_clock_in(bclk), .frame_n_in(frame_bus),
    .frame_n_out(d_frame_n), .frame_oe_out(d_frame_oe), .irdy_n_in(irdy_bus),
    .irdy_n_out(d_irdy_n), .irdy_oe_out(d_irdy_oe), .trdy_n_in(trdy_n),
    .park_n_in(park_n), .tgt_sel_in(tgt_sel), .tgt_rdata_in(tgt_rdata),
    .tgt_be_n_in(tgt_be_n), .ad_in(ad_bus), .ad_out(ad_out),
    .ad_oe_out(ad_oe), .cbe_n_in(cbe_bus), .cbe_n_out(cbe_out),
    .cbe_oe_out(cbe_oe), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
    .rx_be_n_out(rx_be));

  bus_agent u_agent (
    .bclk_in(bclk), .frame_n_in(frame_bus), .irdy_n_in(irdy_bus),
    .ad_in(ad_bus), .cbe_n_in(cbe_bus), .park_n_out(park_n),
    .trdy_n_out(trdy_n), .frame_n_out(a_frame_n), .irdy_n_out(a_irdy_n),
    .strobe_oe_out(a_soe), .ad_out(a_ad), .ad_oe_out(a_ad_oe),
    .cbe_n_out(a_cbe), .cbe_oe_out(a_cbe_oe));

  task automatic check(input logic ok, input string what);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic send_req(input logic [63:0] a, input logic [3:0] c,
                          input logic [7:0] be, input logic [63:0] d);
    int n;
    @(negedge clk);
    req_valid = 1'b1;
    req_addr = a;
    req_cmd = c;
    req_be_n = be;
    req_wdata = d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 2000);
    check(n < 2000, "request never taken");
    @(negedge clk);
    req_valid = 1'b0;
  endtask

  task automatic t_park;
    u_agent.stall(1'b0);
    u_agent.grant(1'b0);
    repeat (3) @(negedge bclk);
    check(ad_oe === 2'h0 && cbe_oe === 2'h0, "parked on busy bus");
    u_agent.stall(1'b1);
    repeat (3) @(negedge bclk);
    check(ad_oe === 2'h3 && cbe_oe === 2'h3, "park lanes");
    check(ad_out === lanes_pkg::AD_PARK_VAL, "park value");
    check(cbe_out === lanes_pkg::CBE_PARK_VAL, "park cbe");
    u_agent.grant(1'b1);
    repeat (3) @(negedge bclk);
    check(ad_oe === 2'h0 && cbe_oe === 2'h0, "park kept");
  endtask

  // device as initiator; waits sets the target's wait states
  task automatic t_init(input logic [3:0] cmd, input int waits);
    logic [63:0] a, wd, rdat;
    logic [7:0]  be, rbe;
    logic        rd;
    int          n0, x0;
    a = 64'h8765_4321_0FED_CBA0 ^ {60'h0, cmd};
    wd = 64'hDEAD_BEEF_0BAD_F00D ^ {60'h0, cmd};
    rdat = 64'h2143_6587_A9CB_ED0F ^ {cmd, 60'h0};
    be = 8'h5A ^ {4'h0, cmd};
    rbe = 8'hA5 ^ {cmd, 4'h0};
    rd = !cmd[lanes_pkg::WR_BIT];
    n0 = rx_cnt;
    x0 = u_agent.xfer_r;
    u_agent.grant(1'b0);
    fork
      send_req(a, cmd, be, wd);
      u_agent.respond(waits, rd, rdat, rbe);
    join
    repeat (4) @(negedge bclk);
    check(u_agent.addr_r === a, "address phase");
    check(u_agent.cmd_r === cmd, "command");
    check(u_agent.xfer_r === x0 + 1, "transfer count");
    if (rd)
      check(rx_cnt === n0 + 1 && {rx_d, rx_b} === {rdat, rbe},
            "read data");
    else
      check(u_agent.data_r === wd && u_agent.be_n_r === be,
            "write data");
    u_agent.grant(1'b1);
  endtask

  // device as target of an outside initiator
  task automatic t_tgt(input logic [3:0] cmd);
    int n0, x0;
    n0 = rx_cnt;
    x0 = u_agent.xfer_r;
    @(negedge bclk);
    tgt_rdata = 64'h0123_4567_89AB_CDEF ^ {60'h0, cmd};
    tgt_be_n = 8'hC3 ^ {cmd, 4'h0};
    tgt_sel = 1'b1;
    u_agent.initiate(64'h0000_0040_1000_0008, cmd, 64'hFACE_0FF1_CE00_7777,
                     8'h3C);
    repeat (3) @(negedge bclk);
    tgt_sel = 1'b0;
    check(u_agent.xfer_r === x0 + 1, "target transfer");
    if (cmd[lanes_pkg::WR_BIT])
      check(rx_cnt === n0 + 1 && rx_b === 8'h3C
            && rx_d === 64'hFACE_0FF1_CE00_7777, "target write");
    else
      check(u_agent.data_r === tgt_rdata
            && u_agent.be_n_r === tgt_be_n, "target read");
    check(ad_oe === 2'h0 && cbe_oe === 2'h0, "target lanes kept");
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #20000;
    bad_count++;
    $display("unexpected at %0t: run hung", $time);
    print_verdict;
  end

  initial
  begin
    // ten core cycles still span enough bus edges for the synced reset
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge bclk);
    check(ad_oe === 2'h0 && cbe_oe === 2'h0 && d_frame_oe === 1'b0,
          "driven after reset");
    t_park;
    t_init(4'h7, 0);
    t_init(4'h6, 3);
    t_init(4'hB, 1);
    t_init(4'hA, 0);
    t_tgt(4'h7);
    t_tgt(4'h6);
    print_verdict;
  end
endmodule
